// File: hdl/ingress_precedence_classifier.sv
// ingress precedence classifier: per-packet precedence lookup with inherit semantics
// assumes upstream logic on clk_sys; dscp and flow-match results arrive with the header
// Summary of operation
// - precedence key is tos bits seven to five
// - dscp match result overrides precedence result
// - class replaced only when entry sets one
// - priority replaced only when entry sets one
// - high priority uses higher admission threshold
// - priority used only for admission, then dropped
// - rewriting an entry replaces it entirely
// - eight entries, one per key 0-7
// - entries evaluated lowest key first
// - eight classes plus optional subclass index
// - unknown subclass write is rejected, flagged
// - removed subclass falls back to parent class
// - override selects exception counter 1 to 8
// - later dscp counter override wins
// - offered stat counts every queued packet
// - queue stats only without exception counter
// - deleting an entry takes effect immediately
// - non-ipv4 packets pass unchanged
`timescale 1ns/10ps
`default_nettype none
module ingress_precedence_classifier
  import ipc_pkg::*;
#(
  parameter int unsigned SUBCLASS_COUNT = 16
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire ipc_pkt_t pktIn,
  input wire logic cfgWrite,
  input wire logic cfgDelete,
  input wire logic [PREC_W-1:0] cfgKey,
  input wire ipc_rule_t cfgRule,
  input wire logic [SUBCLASS_W-1:0] subclassRemoveIdx,
  input wire logic subclassRemove,
  input wire logic [SUBCLASS_W-1:0] subclassAddIdx,
  input wire ipc_class_t subclassAddParent,
  input wire logic subclassAdd,
  input wire logic [FILL_W-1:0] threshHigh,
  input wire logic [FILL_W-1:0] threshLow,
  output logic cfgError,
  output logic [NUM_ENTRIES-1:0] entryPresent,
  output ipc_out_t resOut
);

  typedef struct packed {
    logic [NUM_ENTRIES-1:0] present;
    ipc_rule_t [NUM_ENTRIES-1:0] table_;
    logic [SUBCLASS_COUNT-1:0] subValid;
    ipc_class_t [SUBCLASS_COUNT-1:0] subParent;
    ipc_pkt_t s1;
    logic s1Hit;
    ipc_rule_t s1Rule;
    logic cfgError;
    ipc_out_t out;
  } ipc_state_t;

  ipc_state_t st;
  ipc_state_t next_st;

  function automatic logic [PREC_W-1:0] precKey(input logic [TOS_W-1:0] tos);
    precKey = tos[PREC_LSB +: PREC_W];
  endfunction

  // subclass index 0 means none; a stale index collapses to the parent class
  function automatic logic subOk(input logic [SUBCLASS_W-1:0] idx, input ipc_class_t cls,
                                 input logic [SUBCLASS_COUNT-1:0] v,
                                 input ipc_class_t [SUBCLASS_COUNT-1:0] p);
    subOk = (idx == '0) || (v[idx] && p[idx] == cls);
  endfunction

  always_comb begin
    ipc_result_t r;
    logic [PREC_W-1:0] k;
    logic [FILL_W-1:0] thr;
    r = '0;
    k = '0;
    thr = '0;
    next_st = st;
    next_st.cfgError = 1'b0;

    if (subclassAdd) begin
      next_st.subValid[subclassAddIdx] = 1'b1;
      next_st.subParent[subclassAddIdx] = subclassAddParent;
    end
    if (subclassRemove) begin
      next_st.subValid[subclassRemoveIdx] = 1'b0;
    end

    // stage 1: lookup; table read uses next state so a delete or rewrite applies at once
    if (cfgWrite) begin
      if (cfgRule.classSet && !subOk(cfgRule.subclass, cfgRule.trafficClassSel,
                                     st.subValid, st.subParent)) begin
        next_st.cfgError = 1'b1;
      end else if (cfgRule.exceptionCtr > CTR_MAX) begin
        next_st.cfgError = 1'b1;
      end else begin
        next_st.table_[cfgKey] = cfgRule;
        next_st.present[cfgKey] = 1'b1;
      end
    end else if (cfgDelete) begin
      next_st.present[cfgKey] = 1'b0;
    end

    next_st.s1 = pktIn;
    k = precKey(pktIn.tos);
    // keys are distinct, so the ascending scan yields at most one hit
    next_st.s1Hit = 1'b0;
    next_st.s1Rule = '0;
    for (int i = 0; i < NUM_ENTRIES; i++) begin
      if (!next_st.s1Hit && next_st.present[i] && k == PREC_W'(i)) begin
        next_st.s1Hit = pktIn.isIpv4;
        next_st.s1Rule = next_st.table_[i];
      end
    end

    // stage 2: merge results
    r = st.s1.prior;
    if (st.s1Hit) begin
      if (st.s1Rule.classSet) begin
        r.trafficClassSel = st.s1Rule.trafficClassSel;
        r.subclass = st.s1Rule.subclass;
      end
      if (st.s1Rule.prioSet) begin
        r.prioHigh = st.s1Rule.prioHigh;
      end
      if (st.s1Rule.exceptionCtr != CTR_NONE) begin
        r.exceptionCtr = st.s1Rule.exceptionCtr;
      end
    end
    if (st.s1.isIpv4 && st.s1.dscpHit) begin
      if (st.s1.dscpClassSet) begin
        r.trafficClassSel = st.s1.dscpRes.trafficClassSel;
        r.subclass = st.s1.dscpRes.subclass;
      end
      if (st.s1.dscpPrioSet) begin
        r.prioHigh = st.s1.dscpRes.prioHigh;
      end
      if (st.s1.dscpRes.exceptionCtr != CTR_NONE) begin
        r.exceptionCtr = st.s1.dscpRes.exceptionCtr;
      end
    end
    if (!subOk(r.subclass, r.trafficClassSel, st.subValid, st.subParent)) begin
      r.subclass = '0;
    end

    thr = r.prioHigh ? threshHigh : threshLow;
    next_st.out.valid = st.s1.valid;
    next_st.out.res = r;
    next_st.out.res.prioHigh = 1'b0;
    next_st.out.admit = st.s1.valid && (st.s1.queueFill < thr);
    next_st.out.statOffered = st.s1.valid && next_st.out.admit;
    next_st.out.statQueue = st.s1.valid && (r.exceptionCtr == CTR_NONE);
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign cfgError = st.cfgError;
  assign entryPresent = st.present;
  assign resOut = st.out;

endmodule
`default_nettype wire

// File: hdl/ipc_pkg.sv
// package for the ingress precedence classifier: widths, reset values, result carriers
// assumes one clock domain and a pipelined header parser upstream
package ipc_pkg;
  localparam int unsigned NUM_ENTRIES = 8;
  localparam int unsigned TOS_W = 8;
  localparam int unsigned PREC_LSB = 5;
  localparam int unsigned PREC_W = 3;
  localparam int unsigned DSCP_W = 6;
  localparam int unsigned CLASS_W = 3;
  localparam int unsigned SUBCLASS_W = 4;
  localparam int unsigned CTR_W = 4;
  localparam int unsigned FILL_W = 8;
  localparam logic [CTR_W-1:0] CTR_NONE = 4'h0;
  localparam logic [CTR_W-1:0] CTR_MAX = 4'h8;
  localparam logic [FILL_W-1:0] THRESH_HIGH_RST = 8'hf0;
  localparam logic [FILL_W-1:0] THRESH_LOW_RST = 8'hc0;
  localparam int unsigned LATENCY_CYCLES = 2;

  typedef enum logic [2:0] {
    CLASS_BEST_EFFORT = 3'b000,
    CLASS_LOW_TWO = 3'b001,
    CLASS_ASSURED = 3'b010,
    CLASS_LOW_ONE = 3'b011,
    CLASS_HIGH_TWO = 3'b100,
    CLASS_EXPEDITED = 3'b101,
    CLASS_HIGH_ONE = 3'b110,
    CLASS_NETWORK = 3'b111
  } ipc_class_t;

  typedef struct packed {
    ipc_class_t trafficClassSel;
    logic [SUBCLASS_W-1:0] subclass;
    logic prioHigh;
    logic [CTR_W-1:0] exceptionCtr;
  } ipc_result_t;

  typedef struct packed {
    logic classSet;
    ipc_class_t trafficClassSel;
    logic [SUBCLASS_W-1:0] subclass;
    logic prioSet;
    logic prioHigh;
    logic [CTR_W-1:0] exceptionCtr;
  } ipc_rule_t;

  typedef struct packed {
    logic valid;
    logic isIpv4;
    logic [TOS_W-1:0] tos;
    ipc_result_t prior;
    logic dscpHit;
    logic dscpClassSet;
    logic dscpPrioSet;
    ipc_result_t dscpRes;
    logic [FILL_W-1:0] queueFill;
  } ipc_pkt_t;

  typedef struct packed {
    logic valid;
    ipc_result_t res;
    logic admit;
    logic statOffered;
    logic statQueue;
  } ipc_out_t;
endpackage

// File: verification/ingress_precedence_classifier_tb.sv
// bench: one task per scenario, each drives the classifier and judges it
// assumes the header source model feeds the packet port
`timescale 1ns/10ps
`default_nettype none
module ingress_precedence_classifier_tb;
  import ipc_pkg::*;
  logic clk_sys = 0, arst_n = 0, go = 0, v4 = 1, dh = 0, cfgWrite = 0, cfgDelete = 0;
  logic scAdd = 0, scRem = 0, cfgError;
  logic [2:0] cfgKey = 0;
  logic [7:0] tos = 0, fill = 0, entryPresent;
  ipc_rule_t cfgRule = '0;
  ipc_pkt_t pktIn;
  ipc_out_t resOut;
  int bad_count = 0, cmp_count = 0;
  always #4 clk_sys = ~clk_sys;
  ipc_header_source ipc_header_source_inst (.go, .v4, .dh, .tos, .fill, .pktIn);
  ingress_precedence_classifier ingress_precedence_classifier_inst (.clk_sys, .arst_n,
    .pktIn, .cfgWrite, .cfgDelete, .cfgKey, .cfgRule, .subclassRemoveIdx(4'h3),
    .subclassRemove(scRem), .subclassAddIdx(4'h3), .subclassAddParent(CLASS_HIGH_TWO),
    .subclassAdd(scAdd), .threshHigh(8'h80), .threshLow(8'h40), .cfgError, .entryPresent,
    .resOut);
  task ck(string n, logic [7:0] s, e);
    cmp_count++;
    if (s !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task summarize;
    if (bad_count == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // an idle edge first, so back-to-back calls never re-raise a strobe in one time step
  task cfg(logic [2:0] k, ipc_rule_t r);
    @(posedge clk_sys) #1;
    {cfgWrite, cfgKey, cfgRule} = {1'h1, k, r};
    @(posedge clk_sys) #1 cfgWrite = 0;
  endtask
  // result stands one cycle only, so it is judged right after its edge
  task pk(logic [7:0] t);
    @(posedge clk_sys) #1 cfgDelete = 0;
    {go, tos} = {1'h1, t};
    @(posedge clk_sys) #1 go = 0;
    @(posedge clk_sys) #1 ck("strobe", resOut.valid, 1);
  endtask
  task t_table;
    for (int k = 0; k < 8; k++) begin
      cfg(k, '{1, ipc_class_t'(k), 0, 1, 0, 0});
      pk({k[2:0], 5'h15});
      ck("class", resOut.res.trafficClassSel, k);
    end
    ck("present", entryPresent, 8'hff);
  endtask
  task t_merge;
    cfg(5, '{0, CLASS_BEST_EFFORT, 0, 0, 0, 2});
    pk(8'ha0);
    ck("class", resOut.res.trafficClassSel, CLASS_ASSURED);
    ck("ctr", resOut.res.exceptionCtr, 2);
    ck("qstat", resOut.statQueue, 0);
    dh = 1;
    pk(8'ha0);
    ck("dctr", resOut.res.exceptionCtr, 3);
    v4 = 0;
    pk(8'h20);
    ck("raw", resOut.res.trafficClassSel, CLASS_ASSURED);
    {dh, v4} = 2'h1;
  endtask
  task t_admit;
    fill = 8'h60;
    pk(8'h40);
    ck("admit", resOut.admit, 0);
    ck("offer", resOut.statOffered, 0);
    pk(8'ha0);
    ck("admit", resOut.admit, 1);
    ck("prio", resOut.res.prioHigh, 0);
    fill = 0;
  endtask
  task t_sub;
    cfg(3, '{0, CLASS_BEST_EFFORT, 0, 0, 0, 9});
    ck("err", cfgError, 1);
    cfg(3, '{1, CLASS_HIGH_TWO, 3, 0, 0, 0});
    ck("err", cfgError, 1);
    pk(8'h60);
    ck("kept", resOut.res.trafficClassSel, 3);
    scAdd = 1;
    @(posedge clk_sys) #1 scAdd = 0;
    cfg(3, '{1, CLASS_HIGH_TWO, 3, 0, 0, 0});
    pk(8'h60);
    ck("sub", resOut.res.subclass, 3);
    scRem = 1;
    @(posedge clk_sys) #1 scRem = 0;
    pk(8'h60);
    ck("parent", {resOut.res.trafficClassSel, resOut.res.subclass}, 8'h40);
  endtask
  task t_delete;
    {cfgDelete, cfgKey} = 4'hf;
    pk(8'he0);
    ck("gone", resOut.res.trafficClassSel, CLASS_ASSURED);
    ck("present", entryPresent[7], 0);
  endtask
  initial begin
    repeat (16) @(posedge clk_sys);
    #1 arst_n = 1;
    t_table;
    t_merge;
    t_admit;
    t_sub;
    t_delete;
    summarize;
  end
  initial begin
    #100000 bad_count++;
    summarize;
  end
endmodule
`default_nettype wire

// File: verification/ipc_assertions.sv
// port assertions for the precedence classifier
// assumes one clock and a low-active asynchronous reset
`timescale 1ns/10ps
`default_nettype none
module ipc_checker
  import ipc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire ipc_pkt_t pktIn,
  input wire logic cfgWrite,
  input wire logic cfgDelete,
  input wire logic [PREC_W-1:0] cfgKey,
  input wire logic [NUM_ENTRIES-1:0] entryPresent,
  input wire ipc_out_t resOut
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  a_fixed_latency: assert property (pktIn.valid |-> ##2 resOut.valid)
    else $error("result strobe late");
  a_no_spurious: assert property (resOut.valid |-> $past(pktIn.valid, 2))
    else $error("result without packet");
  a_raw_passes: assert property (pktIn.valid && !pktIn.isIpv4 |-> ##2
    resOut.res.trafficClassSel == $past(pktIn.prior.trafficClassSel, 2)) else $error("raw");
  a_dscp_class: assert property (pktIn.valid && pktIn.isIpv4 && pktIn.dscpHit &&
    pktIn.dscpClassSet |-> ##2 resOut.res.trafficClassSel == $past(pktIn.dscpRes.trafficClassSel, 2))
    else $error("dscp");
  a_dscp_ctr: assert property (pktIn.valid && pktIn.isIpv4 && pktIn.dscpHit &&
    pktIn.dscpRes.exceptionCtr != CTR_NONE |-> ##2
    resOut.res.exceptionCtr == $past(pktIn.dscpRes.exceptionCtr, 2)) else $error("ctr");
  a_queue_stat: assert property (resOut.valid |->
    resOut.statQueue == (resOut.res.exceptionCtr == CTR_NONE)) else $error("queue stat");
  a_prio_spent: assert property (resOut.valid |-> !resOut.res.prioHigh)
    else $error("priority kept");
  a_delete_now: assert property (cfgDelete && !cfgWrite |=> !entryPresent[$past(cfgKey)])
    else $error("entry kept");
endmodule
bind ingress_precedence_classifier ipc_checker ipc_checker_inst (.clk_sys, .arst_n, .pktIn,
  .cfgWrite, .cfgDelete, .cfgKey, .entryPresent, .resOut);
`default_nettype wire

// File: verification/ipc_header_source.sv
// header source model: parsed fields of one packet per go pulse
// assumes its controls change just after a clock edge
`timescale 1ns/10ps
`default_nettype none
module ipc_header_source
  import ipc_pkg::*;
(
  input wire logic go,
  input wire logic v4,
  input wire logic dh,
  input wire logic [7:0] tos,
  input wire logic [7:0] fill,
  output ipc_pkt_t pktIn
);
  always_comb begin
    pktIn = '0;
    {pktIn.valid, pktIn.isIpv4, pktIn.queueFill} = {go, v4, fill};
    // idle header bytes are not held, so show the inverse
    pktIn.tos = go ? tos : ~tos;
    pktIn.prior.trafficClassSel = CLASS_ASSURED;
    pktIn.prior.prioHigh = 1'h1;
    {pktIn.dscpHit, pktIn.dscpClassSet} = {dh, dh};
    pktIn.dscpRes.trafficClassSel = CLASS_HIGH_ONE;
    pktIn.dscpRes.exceptionCtr = 4'h3;
  end
endmodule
`default_nettype wire
